// file: verilog/lin_stepper_slave.sv
/*
 slave end: takes readback preparing frames and answers reading frames
 with the full status (positions) or the parameter memory contents.
 assumes the master modport end paces one byte per enabled cycle.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module lin_stepper_slave #(
    parameter bit FORCE_HOLD_LSB = 1'b0
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // link
    lin_link_if.slave link,
    // node configuration
    input wire logic [5:0] i_prep_id,
    input wire logic [6:0] i_node_address,
    input wire lin_pkg::param_mem_s i_param,
    input wire logic [2:0] i_hardware_address_pins,
    // motion state
    input wire logic [15:0] i_actual_position,
    input wire logic [15:0] i_target_position,
    // status
    output logic o_armed,
    output logic o_frame_error,
    output logic o_served
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX = 2'b01,
        ST_TX = 2'b11
    } state_e;

    state_e state_r, state_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [3:0] len_r, len_nxt;
    logic is8_r, is8_nxt;
    logic armed_r, armed_nxt;
    logic otp_r, otp_nxt;
    logic [7:0] rx_buf_r [0:7];
    logic [7:0] rx_buf_nxt [0:7];
    logic [7:0] tx_buf_r [0:7];
    logic [7:0] tx_buf_nxt [0:7];
    logic s_vld_r, s_vld_nxt;
    logic [7:0] s_byte_r, s_byte_nxt;
    logic err_r, err_nxt;
    logic served_r, served_nxt;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [7:0] resp_otp [0:7];
    logic [7:0] resp_full [0:7];
    logic rx_clr, rx_add, tx_clr, tx_add;
    logic [7:0] rx_sum, tx_sum;
    logic [7:0] cmd_b, adr_b;
    logic fill_ok, form_ok, is_hdr;

    // pins come from outside the clock domain
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else if (i_ce) begin
            pin_s1_r <= i_hardware_address_pins;
            pin_s2_r <= pin_s1_r;
        end
    end

    // answer images, captured whole at the reading identifier
    always_comb begin
        resp_otp[0] = {i_param.oscillator_trim,
                       i_param.current_reference_trim};
        resp_otp[1] = {1'b1, i_param.thermal_shutdown_trim,
                       i_param.bandgap_trim};
        resp_otp[2] = {i_param.address_mode_bit, pin_s2_r,
                       i_param.physical_address};
        resp_otp[3] = {i_param.run_current, i_param.hold_current[3:1],
                       i_param.hold_current[0] | FORCE_HOLD_LSB};
        resp_otp[4] = {i_param.max_velocity,
                       i_param.min_velocity};
        resp_otp[5] = {i_param.secure_position[10:8], i_param.shaft,
                       i_param.acceleration};
        resp_otp[6] = i_param.secure_position[7:0];
        resp_otp[7] = {4'h0, i_param.step_resolution,
                       i_param.lock_bit_trim,
                       i_param.lock_bit_general};
        resp_full[0] = {1'b1, i_node_address};
        resp_full[1] = i_actual_position[15:8];
        resp_full[2] = i_actual_position[7:0];
        resp_full[3] = i_target_position[15:8];
        resp_full[4] = i_target_position[7:0];
        resp_full[5] = i_param.secure_position[7:0];
        resp_full[6] = {5'h1f, i_param.secure_position[10:8]};
        resp_full[7] = lin_pkg::FILL;
    end

    // preparation decode from the stored data bytes
    always_comb begin
        cmd_b = is8_r ? rx_buf_r[1] : rx_buf_r[0];
        adr_b = is8_r ? rx_buf_r[2] : rx_buf_r[1];
        fill_ok = 1'b1;
        for (int i = 3; i < 8; i++) begin
            if (rx_buf_r[i] != lin_pkg::FILL) begin
                fill_ok = 1'b0;
            end
        end
        form_ok = cmd_b[7] && adr_b[7]
                  && (cmd_b[6:0] == lin_pkg::CMD_OTP
                      || cmd_b[6:0] == lin_pkg::CMD_FULL);
        if (is8_r) begin
            form_ok = form_ok && fill_ok
                      && rx_buf_r[0] == lin_pkg::APP_CMD;
        end
    end

    assign is_hdr = link.m_vld && link.m_hdr;

    // frame engine: receive preparations, send answers
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        len_nxt = len_r;
        is8_nxt = is8_r;
        armed_nxt = armed_r;
        otp_nxt = otp_r;
        rx_buf_nxt = rx_buf_r;
        tx_buf_nxt = tx_buf_r;
        s_vld_nxt = 1'b0;
        s_byte_nxt = s_byte_r;
        err_nxt = 1'b0;
        served_nxt = 1'b0;
        rx_clr = 1'b0;
        rx_add = 1'b0;
        tx_clr = 1'b0;
        tx_add = 1'b0;
        case (state_r)
            ST_RX: begin
                if (link.m_vld && !link.m_hdr) begin
                    if (idx_r < len_r) begin
                        rx_buf_nxt[idx_r[2:0]] = link.m_byte;
                        rx_add = 1'b1;
                        idx_nxt = idx_r + 4'h1;
                    end else begin
                        state_nxt = ST_IDLE;
                        if (link.m_byte != rx_sum) begin
                            err_nxt = 1'b1;
                        end else if (form_ok) begin
                            // a valid frame for another node disarms
                            armed_nxt = adr_b[6:0] == i_node_address;
                            otp_nxt = cmd_b[6:0] == lin_pkg::CMD_OTP;
                        end
                    end
                end
            end
            ST_TX: begin
                s_vld_nxt = 1'b1;
                if (idx_r < lin_pkg::RESP_LEN) begin
                    s_byte_nxt = tx_buf_r[idx_r[2:0]];
                    tx_add = 1'b1;
                    idx_nxt = idx_r + 4'h1;
                end else begin
                    s_byte_nxt = tx_sum;
                    served_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
            end
        endcase
        // any identifier restarts decoding, even mid-frame
        if (is_hdr) begin
            idx_nxt = 4'h0;
            rx_clr = 1'b1;
            tx_clr = 1'b1;
            s_vld_nxt = 1'b0;
            served_nxt = 1'b0;
            state_nxt = ST_IDLE;
            if (link.m_byte == lin_pkg::pid(lin_pkg::READ_ID)) begin
                if (armed_r) begin
                    state_nxt = ST_TX;
                    armed_nxt = 1'b0;
                    tx_buf_nxt = otp_r ? resp_otp : resp_full;
                end
            end else if (link.m_byte == lin_pkg::PREP8_PID) begin
                state_nxt = ST_RX;
                is8_nxt = 1'b1;
                len_nxt = lin_pkg::LEN8;
            end else if (link.m_byte == lin_pkg::pid(i_prep_id)) begin
                state_nxt = ST_RX;
                is8_nxt = 1'b0;
                len_nxt = lin_pkg::LEN7;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            idx_r <= 4'h0;
            len_r <= 4'h0;
            is8_r <= 1'b0;
            armed_r <= 1'b0;
            otp_r <= 1'b0;
            rx_buf_r <= '{default: 8'h00};
            tx_buf_r <= '{default: 8'h00};
            s_vld_r <= 1'b0;
            s_byte_r <= 8'h00;
            err_r <= 1'b0;
            served_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            len_r <= len_nxt;
            is8_r <= is8_nxt;
            armed_r <= armed_nxt;
            otp_r <= otp_nxt;
            rx_buf_r <= rx_buf_nxt;
            tx_buf_r <= tx_buf_nxt;
            s_vld_r <= s_vld_nxt;
            s_byte_r <= s_byte_nxt;
            err_r <= err_nxt;
            served_r <= served_nxt;
        end
    end

    // receive and transmit sums
    lin_checksum u_rx_sum (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_clear(rx_clr),
        .i_add(rx_add),
        .i_byte(link.m_byte),
        .o_sum(rx_sum)
    );

    lin_checksum u_tx_sum (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_clear(tx_clr),
        .i_add(tx_add),
        .i_byte(s_byte_nxt),
        .o_sum(tx_sum)
    );

    assign link.s_vld = s_vld_r;
    assign link.s_byte = s_byte_r;
    assign o_armed = armed_r;
    assign o_frame_error = err_r;
    assign o_served = served_r;
endmodule : lin_stepper_slave

// file: verilog/lin_pkg.sv
/*
 package for the stepper slave readback logic and its bus master:
 frame identifiers, command codes, frame lengths, register map.
 assumes the byte-level link carried by lin_link_if.
*/
package lin_pkg;
    // frame identifiers and command codes
    localparam logic [5:0] READ_ID = 6'h3d;
    localparam logic [7:0] PREP8_PID = 8'h3c;
    localparam logic [7:0] APP_CMD = 8'h50;
    localparam logic [6:0] CMD_FULL = 7'h01;
    localparam logic [6:0] CMD_OTP = 7'h02;
    localparam logic [7:0] FILL = 8'hff;
    // frame lengths in data bytes
    localparam logic [3:0] LEN7 = 4'h2;
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] RESP_LEN = 4'h8;
    // master waits this many cycles for each answer byte
    localparam logic [3:0] WAIT_CYC = 4'h8;
    // master register map (byte offsets) and control fields
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] DLO_OFS = 8'h08;
    localparam logic [7:0] DHI_OFS = 8'h0c;
    localparam int CTRL_START = 0;
    localparam int CTRL_FORM8 = 1;
    localparam int CTRL_CMD = 8;
    localparam int CTRL_ADDR = 16;
    localparam int CTRL_PID = 24;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // parameter memory contents of the slave
    typedef struct packed {
        logic [3:0] oscillator_trim;
        logic [3:0] current_reference_trim;
        logic [2:0] thermal_shutdown_trim;
        logic [3:0] bandgap_trim;
        logic address_mode_bit;
        logic [3:0] physical_address;
        logic [3:0] run_current;
        logic [3:0] hold_current;
        logic [3:0] max_velocity;
        logic [3:0] min_velocity;
        logic [10:0] secure_position;
        logic shaft;
        logic [3:0] acceleration;
        logic [1:0] step_resolution;
        logic lock_bit_trim;
        logic lock_bit_general;
    } param_mem_s;

    // protected identifier: two parity bits above the 6-bit id
    function automatic logic [7:0] pid(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id};
    endfunction : pid
endpackage : lin_pkg

// file: verilog/lin_link_if.sv
/*
 byte-level link between bus master and stepper slave.
 assumes both ends share i_clk; one byte per valid cycle.
*/
`timescale 1ns/1ps
interface lin_link_if;
    logic m_vld;        // master byte present
    logic m_hdr;        // master byte is a frame identifier
    logic [7:0] m_byte;
    logic s_vld;        // slave answer byte present
    logic [7:0] s_byte;
    modport master (output m_vld, output m_hdr, output m_byte,
                    input s_vld, input s_byte);
    modport slave (input m_vld, input m_hdr, input m_byte,
                   output s_vld, output s_byte);
endinterface : lin_link_if

// file: verilog/lin_checksum.sv
/*
 running checksum: sum with end-around carry, inverted on output.
 assumes the caller clears it at each frame identifier.
*/
`timescale 1ns/1ps
module lin_checksum (
    // clock and control
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // accumulate
    input wire logic i_clear,
    input wire logic i_add,
    input wire logic [7:0] i_byte,
    // inverted sum
    output logic [7:0] o_sum
);
    logic [7:0] sum_r;
    logic [7:0] sum_nxt;
    logic [7:0] base;
    logic [8:0] wide;

    // clear and add in one cycle start a fresh sum with that byte
    always_comb begin
        base = i_clear ? 8'h00 : sum_r;
        wide = {1'b0, base} + {1'b0, i_byte};
        sum_nxt = base;
        if (i_add) begin
            sum_nxt = wide[7:0] + {7'h00, wide[8]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sum_r <= 8'h00;
        end else if (i_ce) begin
            sum_r <= sum_nxt;
        end
    end

    assign o_sum = ~sum_r;
endmodule : lin_checksum

// file: verilog/lin_master_ctrl.sv
/*
 master end: software starts a preparing frame plus reading frame
 through APB registers and collects the eight answer bytes.
 assumes a zero-wait APB master and one shared clock with the slave.
*/
`timescale 1ns/1ps
module lin_master_ctrl (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // link
    lin_link_if.master link
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PREP = 2'b01,
        ST_READ = 2'b11,
        ST_WAIT = 2'b10
    } state_e;

    state_e state_r, state_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic [3:0] tmr_r, tmr_nxt;
    logic ok_r, ok_nxt, tmo_r, tmo_nxt, cerr_r, cerr_nxt;
    logic [7:0] data_r [0:7];
    logic [7:0] data_nxt [0:7];
    logic m_vld_r, m_vld_nxt, m_hdr_r, m_hdr_nxt;
    logic [7:0] m_byte_r, m_byte_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pslverr_r, pslverr_nxt;
    logic [7:0] pb [0:8];
    logic [3:0] len;
    logic [7:0] ck_sum, ck_byte;
    logic ck_clr, ck_add, wr, start;
    logic [6:0] cmd, adr;

    assign cmd = ctrl_r[lin_pkg::CTRL_CMD +: 7];
    assign adr = ctrl_r[lin_pkg::CTRL_ADDR +: 7];
    assign wr = i_psel && i_penable && pready_r && i_pwrite;
    assign start = wr && i_paddr == lin_pkg::CTRL_OFS
                   && i_pwdata[lin_pkg::CTRL_START]
                   && state_r == ST_IDLE;

    // preparing frame image, identifier first
    always_comb begin
        pb = '{default: lin_pkg::FILL};
        if (ctrl_r[lin_pkg::CTRL_FORM8]) begin
            pb[0] = lin_pkg::PREP8_PID;
            pb[1] = lin_pkg::APP_CMD;
            pb[2] = {1'b1, cmd};
            pb[3] = {1'b1, adr};
            len = lin_pkg::LEN8;
        end else begin
            pb[0] = lin_pkg::pid(ctrl_r[lin_pkg::CTRL_PID +: 6]);
            pb[1] = {1'b1, cmd};
            pb[2] = {1'b1, adr};
            len = lin_pkg::LEN7;
        end
    end

    // frame sequencer: prepare, read, collect
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        tmr_nxt = tmr_r;
        ok_nxt = ok_r;
        tmo_nxt = tmo_r;
        cerr_nxt = cerr_r;
        data_nxt = data_r;
        m_vld_nxt = 1'b0;
        m_hdr_nxt = 1'b0;
        m_byte_nxt = m_byte_r;
        ck_clr = 1'b0;
        ck_add = 1'b0;
        ck_byte = pb[idx_r];
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_PREP;
                    idx_nxt = 4'h0;
                    ok_nxt = 1'b0;
                    tmo_nxt = 1'b0;
                    cerr_nxt = 1'b0;
                end
            end
            ST_PREP: begin
                m_vld_nxt = 1'b1;
                m_hdr_nxt = idx_r == 4'h0;
                idx_nxt = idx_r + 4'h1;
                if (idx_r == 4'h0) begin
                    m_byte_nxt = pb[0];
                    ck_clr = 1'b1;
                end else if (idx_r <= len) begin
                    m_byte_nxt = pb[idx_r];
                    ck_add = 1'b1;
                end else begin
                    m_byte_nxt = ck_sum;
                    state_nxt = ST_READ;
                end
            end
            ST_READ: begin
                m_vld_nxt = 1'b1;
                m_hdr_nxt = 1'b1;
                m_byte_nxt = lin_pkg::pid(lin_pkg::READ_ID);
                ck_clr = 1'b1;
                idx_nxt = 4'h0;
                tmr_nxt = 4'h0;
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                ck_byte = link.s_byte;
                tmr_nxt = tmr_r + 4'h1;
                if (link.s_vld) begin
                    tmr_nxt = 4'h0;
                    idx_nxt = idx_r + 4'h1;
                    if (idx_r < lin_pkg::RESP_LEN) begin
                        data_nxt[idx_r[2:0]] = link.s_byte;
                        ck_add = 1'b1;
                    end else begin
                        ok_nxt = link.s_byte == ck_sum;
                        cerr_nxt = link.s_byte != ck_sum;
                        state_nxt = ST_IDLE;
                    end
                end else if (tmr_r == lin_pkg::WAIT_CYC) begin
                    tmo_nxt = 1'b1; // silent slave
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // apb: zero-wait answer, registered read data
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (start) begin
            ctrl_nxt = i_pwdata;
            ctrl_nxt[lin_pkg::CTRL_START] = 1'b0;
        end
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (i_paddr == lin_pkg::CTRL_OFS) begin
            prdata_nxt = ctrl_r;
        end else if (i_paddr == lin_pkg::STAT_OFS) begin
            prdata_nxt = {28'h000_0000, cerr_r, tmo_r, ok_r,
                          state_r != ST_IDLE};
        end else if (i_paddr == lin_pkg::DLO_OFS) begin
            prdata_nxt = {data_r[3], data_r[2], data_r[1], data_r[0]};
        end else if (i_paddr == lin_pkg::DHI_OFS) begin
            prdata_nxt = {data_r[7], data_r[6], data_r[5], data_r[4]};
        end else begin
            pslverr_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            ctrl_r <= lin_pkg::CTRL_RST;
            idx_r <= 4'h0;
            tmr_r <= 4'h0;
            ok_r <= 1'b0;
            tmo_r <= 1'b0;
            cerr_r <= 1'b0;
            data_r <= '{default: 8'h00};
            m_vld_r <= 1'b0;
            m_hdr_r <= 1'b0;
            m_byte_r <= 8'h00;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            idx_r <= idx_nxt;
            tmr_r <= tmr_nxt;
            ok_r <= ok_nxt;
            tmo_r <= tmo_nxt;
            cerr_r <= cerr_nxt;
            data_r <= data_nxt;
            m_vld_r <= m_vld_nxt;
            m_hdr_r <= m_hdr_nxt;
            m_byte_r <= m_byte_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= i_psel && !i_penable;
            pslverr_r <= i_psel && !i_penable && pslverr_nxt;
        end
    end

    lin_checksum u_sum (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_clear(ck_clr),
        .i_add(ck_add),
        .i_byte(ck_byte),
        .o_sum(ck_sum)
    );

    assign link.m_vld = m_vld_r;
    assign link.m_hdr = m_hdr_r;
    assign link.m_byte = m_byte_r;
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
endmodule : lin_master_ctrl

// file: testbench/lin_sva.sv
/*
 link checker: preparing frame layout, answer timing, length, checksum.
 assumes one shared clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module lin_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // link signals
    input wire logic m_vld,
    input wire logic m_hdr,
    input wire logic [7:0] m_byte,
    input wire logic s_vld,
    input wire logic [7:0] s_byte
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sum_r;
    logic [7:0] sum_nxt;
    logic [8:0] add;
    // running answer sum; end-around carry cannot overflow a second time
    always_comb begin
        add = {1'b0, sum_r} + {1'b0, s_byte};
        cnt_nxt = s_vld ? cnt_r + 4'h1 : 4'h0;
        sum_nxt = s_vld ? add[7:0] + {7'h00, add[8]} : 8'h00;
    end
    // register the helper state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_r <= 4'h0;
            sum_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
            sum_r <= sum_nxt;
        end
    end
    // eight data bytes plus checksum, then silence
    sequence s_answer;
        s_vld [*8] ##1 s_vld ##1 !s_vld;
    endsequence
    // checksum then reading header right behind it
    sequence s_tail;
        m_vld && !m_hdr ##1 m_vld && m_hdr && m_byte == 8'h7d;
    endsequence
    a_hdr_lead: assert property ($rose(s_vld) |->
        $past(m_hdr, 2) && $past(m_byte, 2) == 8'h7d)
        else $error("answer without reading header");
    a_nine_bytes: assert property ($rose(s_vld) |-> s_answer)
        else $error("answer length wrong");
    a_sum_match: assert property (s_vld && cnt_r == 4'h8 |->
        s_byte == ~sum_r) else $error("answer checksum wrong");
    a_prep_short: assert property (m_vld && m_hdr && m_byte != 8'h7d
        && m_byte != 8'h3c |=> m_byte inside {8'h81, 8'h82} ##1
        m_vld && m_byte[7] ##1 s_tail) else $error("short prep bad");
    a_prep_long: assert property (m_vld && m_hdr && m_byte == 8'h3c
        |=> m_byte == 8'h50 ##1 m_byte inside {8'h81, 8'h82} ##1
        m_byte[7] ##1 (m_vld && m_byte == 8'hff) [*5] ##1 s_tail)
        else $error("long prep bad");
    a_hdr_valid: assert property (m_hdr |-> m_vld)
        else $error("header flag without byte");
    a_no_overlap: assert property (s_vld |-> !m_vld)
        else $error("master talks over answer");
    a_silent_other: assert property (m_vld && m_hdr &&
        m_byte != 8'h7d |-> ##1 !s_vld ##1 !s_vld)
        else $error("answer after other header");
endmodule : lin_sva

// file: testbench/tb_lin_status_otp_readback.sv
/*
 testbench: both link ends joined, driven through the master's APB port.
 assumes a zero-wait APB slave; answers land in DLO and DHI.
*/
`timescale 1ns/1ps
module tb_lin_status_otp_readback;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] addr_pins = 3'h5;
    logic armed;
    logic ferr;
    logic served;
    logic [31:0] n_armed = 32'h0000_0000;
    logic [31:0] n_ferr = 32'h0000_0000;
    logic [31:0] n_served = 32'h0000_0000;
    logic [15:0] act = 16'h1234;
    logic [15:0] tgt = 16'hbeef;
    lin_pkg::param_mem_s prm = '{4'ha, 4'h5, 3'h6, 4'h9, 1'b1, 4'h3, 4'hc,
        4'h4, 4'he, 4'h2, 11'h5a3, 1'b1, 4'h7, 2'h2, 1'b1, 1'b0};
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int n_tests = 0;
    lin_link_if link();
    always #10 i_clk = ~i_clk;
    // count slave status cycles: each answer arms one cycle, serves once
    always @(posedge i_clk) begin
        n_armed <= n_armed + {31'h0, armed === 1'b1};
        n_ferr <= n_ferr + {31'h0, ferr === 1'b1};
        n_served <= n_served + {31'h0, served === 1'b1};
    end
    // hold lsb forced so the variant behaviour is visible
    lin_stepper_slave #(.FORCE_HOLD_LSB(1'b1)) u_lin_stepper_slave (
        .i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .link(link),
        .i_prep_id(6'h11), .i_node_address(7'h15), .i_param(prm),
        .i_hardware_address_pins(addr_pins), .i_actual_position(act),
        .i_target_position(tgt), .o_armed(armed), .o_frame_error(ferr),
        .o_served(served));
    lin_master_ctrl u_lin_master_ctrl (.i_clk(i_clk), .i_srst(i_srst),
        .i_ce(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .link(link));
    lin_sva u_lin_sva (.i_clk(i_clk), .i_srst(i_srst),
        .m_vld(link.m_vld), .m_hdr(link.m_hdr), .m_byte(link.m_byte),
        .s_vld(link.s_vld), .s_byte(link.s_byte));
    // one apb transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] ctrl(input logic f,
        input logic [6:0] cmd, input logic [6:0] ad, input logic [5:0] id);
        return {2'b00, id, 1'b0, ad, 1'b0, cmd, 6'h00, f, 1'b1};
    endfunction : ctrl
    // start a transaction, poll busy with a bound, check the results
    task automatic run(input logic [31:0] c, input logic [31:0] st,
                       input logic [31:0] lo, input logic [31:0] hi);
        int i;
        apb(1'b1, lin_pkg::CTRL_OFS, c);
        i = 0;
        do begin
            apb(1'b0, lin_pkg::STAT_OFS, 32'h0000_0000);
            i++;
        end while (rd[0] !== 1'b0 && i < 60);
        chk(rd, st);
        // a silent slave leaves the data registers undefined by contract
        if (st == 32'h0000_0002) begin
            apb(1'b0, lin_pkg::DLO_OFS, 32'h0000_0000);
            chk(rd, lo);
            apb(1'b0, lin_pkg::DHI_OFS, 32'h0000_0000);
            chk(rd, hi);
        end
        apb(1'b0, lin_pkg::CTRL_OFS, 32'h0000_0000);
        chk(rd, c & ~32'h0000_0001);
        $display("test done ctrl=%h", c);
    endtask : run
    task stop_test;
        $display("checks=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        run(ctrl(1'b0, 7'h02, 7'h15, 6'h11), 32'h0000_0002, 32'hc5d3_e9a5,
            32'h0aa3_b7e2);
        addr_pins <= 3'h2;
        run(ctrl(1'b1, 7'h02, 7'h15, 6'h11), 32'h0000_0002, 32'hc5a3_e9a5,
            32'h0aa3_b7e2);
        run(ctrl(1'b0, 7'h01, 7'h15, 6'h11), 32'h0000_0002, 32'hbe34_1295,
            32'hfffd_a3ef);
        run(ctrl(1'b1, 7'h02, 7'h16, 6'h11), 32'h0000_0004, 32'h0000_0000,
            32'h0000_0000);
        run(ctrl(1'b0, 7'h02, 7'h15, 6'h12), 32'h0000_0004, 32'h0000_0000,
            32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        $display("test done unmapped");
        chk(n_armed, 32'h0000_0003);
        chk(n_served, 32'h0000_0003);
        chk(n_ferr, 32'h0000_0000);
        $display("test done status pulses");
        stop_test;
    end
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #400_000;
        err_total++;
        stop_test;
    end
endmodule : tb_lin_status_otp_readback
